/* core/tgc_defines.vh */
`ifndef TGC_DEFINES_VH
`define TGC_DEFINES_VH
// register word indices (byte address is four times the index)
`define TGC_REG_TIMER_CTRL 3'h0
`define TGC_REG_GATE_CTRL  3'h1
`define TGC_REG_COUNT_LOW  3'h2
`define TGC_REG_COUNT_HIGH 3'h3
`define TGC_REG_CMP_LOW    3'h4
`define TGC_REG_CMP_HIGH   3'h5
`define TGC_REG_CCP_CTRL   3'h6
`define TGC_REG_FLAGS      3'h7
// timer_control fields
`define TGC_TC_ON          0
`define TGC_TC_SYNC_DIS    2
`define TGC_TC_OSC_EN      3
`define TGC_TC_PS_LO       4
`define TGC_TC_CS_LO       6
// gate_control fields
`define TGC_GC_GSS_LO      0
`define TGC_GC_GVAL        2
`define TGC_GC_ARMED       3
`define TGC_GC_SPM         4
`define TGC_GC_GTM         5
`define TGC_GC_GPOL        6
`define TGC_GC_GE          7
// ccp_control fields
`define TGC_CC_CAP_EN      0
`define TGC_CC_CMP_EN      1
`define TGC_CC_SPECIAL_EN  2
// flags fields
`define TGC_FL_OVF         0
`define TGC_FL_GATE        1
`define TGC_FL_CMP         2
`define TGC_FL_CAP         3
// clock source codes
`define TGC_CS_INSTR       2'h0
`define TGC_CS_SYS         2'h1
`define TGC_CS_PIN         2'h2
`define TGC_CS_CAP_SENSE_OSCILLATOR      2'h3
// gate source codes
`define TGC_GS_PIN         2'h0
`define TGC_GS_TMR0        2'h1
`define TGC_GS_SECOND_TIMER_COUNT        2'h2
`define TGC_GS_WDT         2'h3
// reset values
`define TGC_RST_CTRL       8'h00
`define TGC_RST_COUNT      16'h0000
// instruction clock is system clock divided by four
`define TGC_INSTR_DIV      2'h3
`endif

/* core/tgc_gate.v */
`timescale 1ns/1ns
`include "tgc_defines.vh"
// gate path: source select, polarity, toggle, single pulse
module tgc_gate (
  // clock and reset
  input  wire       clk,
  input  wire       resetn,
  // gate sources
  input  wire       gate_pin,
  input  wire       timer0_overflow,
  input  wire       second_timer_match,
  input  wire       wdt_scaler_overflow,
  // settings
  input  wire [1:0] gate_source_select,
  input  wire       gate_polarity,
  input  wire       gate_toggle_mode,
  input  wire       gate_single_pulse_mode,
  input  wire       timer_on,
  input  wire       arm_set,
  // status
  output reg        gate_current_level,
  output reg        single_pulse_armed,
  output reg        gate_falling
);
  reg  src;                 // selected raw source
  wire pol_g;               // gate after polarity
  reg  pol_prev_ff;         // last polarity-applied level
  reg  tog_ff;              // toggle flip-flop
  reg  tog_prev_ff;         // last toggled level
  reg  run_ff;              // single pulse in progress
  wire tg;                  // gate after toggle stage
  wire tg_rise;
  wire tg_fall;
  reg  nxt_gval;

  // source multiplexer
  always @* begin
    case (gate_source_select)
      `TGC_GS_PIN:  src = gate_pin;            // see [R18]
      `TGC_GS_TMR0: src = timer0_overflow;     // see [R18]
      `TGC_GS_SECOND_TIMER_COUNT: src = second_timer_match;  // see [R18]
      default:      src = wdt_scaler_overflow; // see [R18]
    endcase
  end

  // active-high when polarity is one
  assign pol_g   = gate_polarity ? src : ~src;  // see [R14]
  assign tg      = gate_toggle_mode ? tog_ff : pol_g;
  assign tg_rise = tg & ~tog_prev_ff;
  assign tg_fall = ~tg & tog_prev_ff;

  // toggle flip-flop, held clear when off
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tog_ff      <= 1'b0;
      pol_prev_ff <= 1'b0;
    end else begin
      pol_prev_ff <= pol_g;
      if (!gate_toggle_mode || !timer_on) begin
        tog_ff <= 1'b0; // see [R15] [R12]
      end else if (pol_g && !pol_prev_ff) begin
        tog_ff <= ~tog_ff; // see [R15]
      end
    end
  end

  // single pulse arm, run and done
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      single_pulse_armed <= 1'b0;
      run_ff             <= 1'b0;
      tog_prev_ff        <= 1'b0;
    end else begin
      tog_prev_ff <= tg;
      if (!gate_single_pulse_mode) begin
        single_pulse_armed <= 1'b0;          // see [R16]
        run_ff             <= 1'b0;
      end else if (arm_set) begin
        single_pulse_armed <= 1'b1;          // see [R16]
        run_ff             <= 1'b0;
      end else if (single_pulse_armed && !run_ff && tg_rise) begin
        run_ff <= 1'b1; // see [R20]
      end else if (run_ff && tg_fall) begin
        run_ff             <= 1'b0;          // see [R20]
        single_pulse_armed <= 1'b0;
      end
    end
  end

  // level that could reach the counter
  always @* begin
    if (gate_single_pulse_mode) begin
      nxt_gval = run_ff & tg & ~tg_fall;     // see [R20]
    end else begin
      nxt_gval = tg; // see [R17]
    end
  end

  // registered status and falling edge event
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gate_current_level <= 1'b0;
      gate_falling       <= 1'b0;
    end else begin
      gate_current_level <= nxt_gval;                        // see [R17]
      gate_falling       <= gate_current_level & ~nxt_gval;  // see [R21]
    end
  end
endmodule

/* core/tgc_timer.v */
// Summary of operation
// [R1] capture copies running count into compare pair
// [R2] compare event when pair equals count
// [R3] special trigger clears count, pair is period
// [R4] special trigger clear sets no overflow flag
// [R5] software should use synchronised clock with trigger
// [R6] count write wins over trigger clear
// [R7] external counting needs falling edge first
// [R8] clock source: cap_sense_oscillator, pin, system, instruction
// [R9] pin source: clock pin or crystal pins
// [R10] prescaler divides by 1, 2, 4, 8
// [R11] sync bit used only for codes 0x
// [R12] timer-on enables counting, off clears toggle
// [R13] gate enable makes counting follow gate
// [R14] gate polarity selects active high or low
// [R15] toggle mode flips gate on rising edges
// [R16] armed status bit, cleared with single pulse
// [R17] gate current level readable always
// [R18] gate source: pin, timer0, timer2, watchdog
// [R19] watchdog gate source enables watchdog oscillator
// [R20] single pulse counts one pulse, then done
// [R21] gate event flag on gate level fall
// [R22] count rolls over, sets overflow flag
// [R23] count advances on enabled prescaled edge
`timescale 1ns/1ns
`include "tgc_defines.vh"
module tgc_timer (
  // clock and reset
  input  wire        clk,
  input  wire        resetn,
  // avalon-mm slave
  input  wire [2:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  input  wire [3:0]  byteenable,
  output reg  [31:0] readdata,
  output wire        waitrequest,
  // clock sources
  input  wire        cap_sense_oscillator,
  input  wire        external_clock_pin,
  input  wire        crystal_in_pin,
  // gate sources
  input  wire        gate_pin,
  input  wire        timer0_overflow,
  input  wire        second_timer_match,
  input  wire        wdt_scaler_overflow,
  // capture/compare side
  input  wire        capture_event,
  output reg         compare_event,
  // status
  output reg  [15:0] count_value,
  output reg         overflow_flag,
  output reg         gate_event_flag,
  output wire        wdt_osc_enable
);
  // registers
  reg  [7:0]  timer_control_ff;    // clock, prescale, sync, on
  reg  [7:0]  gate_ctrl_ff;        // writable gate settings
  reg  [15:0] compare_value_ff;    // compare_value_high:low
  reg  [2:0]  ccp_ctrl_ff;         // capture, compare, trigger
  reg         cmp_flag_ff;         // sticky compare flag
  reg         cap_flag_ff;         // sticky capture flag
  reg         ack_ff;              // bus answer cycle
  reg  [7:0]  nxt_rd;              // read mux
  // clock path
  reg  [1:0]  div_ff;              // instruction clock divider
  reg         instr_en;            // one cycle in four
  reg         pin_a_ff;            // pin sample stage
  reg         pin_b_ff;            // pin previous sample
  reg         fell_ff;             // falling edge registered
  reg         sync_tick_ff;        // synchronised tick
  reg  [2:0]  pre_ff;              // prescale counter
  reg         raw_tick;
  reg         src_lvl;
  reg         tick;
  reg         pre_tick;
  reg  [2:0]  pre_max;
  // gate
  wire        gval;
  wire        armed;
  wire        gfall;
  wire        arm_set;
  // control fields
  wire [1:0]  clock_source_select;
  wire [1:0]  input_prescale_select;
  wire        dedicated_osc_enable;
  wire        input_sync_disable;
  wire        timer_on;
  wire        gate_enable;
  wire [1:0]  gate_source_select;
  // bus strobes
  wire        wr_go;
  wire        wr_lo;
  wire        wr_hi;
  wire        fl_wr;
  wire        cnt_en;
  wire        match;
  reg         match_prev_ff;
  wire        special_clr;
  wire [16:0] cnt_inc;

  assign clock_source_select   = timer_control_ff[`TGC_TC_CS_LO+1:`TGC_TC_CS_LO];
  assign input_prescale_select = timer_control_ff[`TGC_TC_PS_LO+1:`TGC_TC_PS_LO];
  assign dedicated_osc_enable  = timer_control_ff[`TGC_TC_OSC_EN];
  assign input_sync_disable    = timer_control_ff[`TGC_TC_SYNC_DIS];
  assign timer_on              = timer_control_ff[`TGC_TC_ON];
  assign gate_enable           = gate_ctrl_ff[`TGC_GC_GE];
  assign gate_source_select    = gate_ctrl_ff[`TGC_GC_GSS_LO+1:`TGC_GC_GSS_LO];

  // one wait cycle, then answer
  assign waitrequest = (read | write) & ~ack_ff;
  assign wr_go       = write & ~waitrequest & byteenable[0];
  assign wr_lo       = wr_go & (address == `TGC_REG_COUNT_LOW);
  assign wr_hi       = wr_go & (address == `TGC_REG_COUNT_HIGH);
  assign fl_wr       = wr_go & (address == `TGC_REG_FLAGS);
  assign arm_set     = wr_go & (address == `TGC_REG_GATE_CTRL) &
                       writedata[`TGC_GC_ARMED] & gate_ctrl_ff[`TGC_GC_SPM] &
                       writedata[`TGC_GC_SPM];

  // watchdog oscillator request, independent of timer-on
  assign wdt_osc_enable = gate_enable &
    (gate_source_select == `TGC_GS_WDT); // see [R19]

  // gate logic
  tgc_gate u_gate (
    .clk                    (clk),
    .resetn                 (resetn),
    .gate_pin               (gate_pin),
    .timer0_overflow        (timer0_overflow),
    .second_timer_match     (second_timer_match),
    .wdt_scaler_overflow    (wdt_scaler_overflow),
    .gate_source_select     (gate_source_select),
    .gate_polarity          (gate_ctrl_ff[`TGC_GC_GPOL]),
    .gate_toggle_mode       (gate_ctrl_ff[`TGC_GC_GTM]),
    .gate_single_pulse_mode (gate_ctrl_ff[`TGC_GC_SPM]),
    .timer_on               (timer_on),
    .arm_set                (arm_set),
    .gate_current_level     (gval),
    .single_pulse_armed     (armed),
    .gate_falling           (gfall)
  );

  // instruction clock divider
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_ff   <= 2'h0;
      instr_en <= 1'b0;
    end else begin
      div_ff   <= div_ff + 2'h1;
      instr_en <= (div_ff == `TGC_INSTR_DIV);
    end
  end

  // external level from cap sense oscillator, pin or crystal
  always @* begin
    if (clock_source_select == `TGC_CS_CAP_SENSE_OSCILLATOR) begin
      src_lvl = cap_sense_oscillator; // see [R8]
    end else if (dedicated_osc_enable) begin
      src_lvl = crystal_in_pin; // see [R9]
    end else begin
      src_lvl = external_clock_pin; // see [R9]
    end
  end

  // external sampling and falling-edge qualifier
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_a_ff <= 1'b0;
      pin_b_ff <= 1'b0;
      fell_ff  <= 1'b0;
    end else begin
      pin_a_ff <= src_lvl;
      pin_b_ff <= pin_a_ff;
      if (!timer_on || !clock_source_select[1]) begin
        fell_ff <= 1'b0; // see [R7]
      end else if (!pin_a_ff && pin_b_ff) begin
        fell_ff <= 1'b1; // see [R7]
      end
    end
  end

  // raw tick per clock source
  always @* begin
    case (clock_source_select)
      `TGC_CS_INSTR: raw_tick = instr_en; // see [R8]
      `TGC_CS_SYS:   raw_tick = 1'b1; // see [R8]
      default:       raw_tick = pin_a_ff & ~pin_b_ff & fell_ff; // see [R7] [R8]
    endcase
  end

  // synchronised or direct tick for internal sources
  always @* begin
    if (clock_source_select[1] || input_sync_disable) begin
      tick = raw_tick; // see [R11]
    end else begin
      tick = sync_tick_ff; // see [R11]
    end
  end

  // prescale terminal value
  always @* begin
    case (input_prescale_select)
      2'h0:    pre_max = 3'h0; // see [R10]
      2'h1:    pre_max = 3'h1;
      2'h2:    pre_max = 3'h3;
      default: pre_max = 3'h7;
    endcase
  end

  // prescaler, cleared on count writes
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pre_ff       <= 3'h0;
      sync_tick_ff <= 1'b0;
    end else begin
      sync_tick_ff <= raw_tick;
      if (wr_lo || wr_hi || !timer_on) begin
        pre_ff <= 3'h0;
      end else if (tick) begin
        pre_ff <= (pre_ff >= pre_max) ? 3'h0 : pre_ff + 3'h1;   // see [R10]
      end
    end
  end

  always @* begin
    pre_tick = tick & (pre_ff >= pre_max); // see [R10]
  end

  // count enable with gate
  assign cnt_en  = timer_on & pre_tick & (~gate_enable | gval); // see [R12] [R13] [R23]
  assign cnt_inc = {1'b0, count_value} + 17'h00001;
  assign match   = ccp_ctrl_ff[`TGC_CC_CMP_EN] & (compare_value_ff == count_value); // see [R2]
  assign special_clr = match & ~match_prev_ff & ccp_ctrl_ff[`TGC_CC_SPECIAL_EN];   // see [R3]

  // running count
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_value <= `TGC_RST_COUNT;
    end else if (wr_lo) begin
      count_value[7:0] <= writedata[7:0]; // see [R6]
    end else if (wr_hi) begin
      count_value[15:8] <= writedata[7:0]; // see [R6]
    end else if (special_clr) begin
      count_value <= `TGC_RST_COUNT; // see [R3]
    end else if (cnt_en) begin
      count_value <= cnt_inc[15:0]; // see [R22] [R23]
    end
  end

  // compare edge, capture and compare registers
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      match_prev_ff    <= 1'b0;
      compare_event    <= 1'b0;
      compare_value_ff <= `TGC_RST_COUNT;
    end else begin
      match_prev_ff <= match;
      compare_event <= match & ~match_prev_ff; // see [R2]
      if (capture_event && ccp_ctrl_ff[`TGC_CC_CAP_EN]) begin
        compare_value_ff <= count_value; // see [R1]
      end else if (wr_go && address == `TGC_REG_CMP_LOW) begin
        compare_value_ff[7:0] <= writedata[7:0];
      end else if (wr_go && address == `TGC_REG_CMP_HIGH) begin
        compare_value_ff[15:8] <= writedata[7:0];
      end
    end
  end

  // sticky flags, set wins over write-one clear
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      overflow_flag   <= 1'b0;
      gate_event_flag <= 1'b0;
      cmp_flag_ff     <= 1'b0;
      cap_flag_ff     <= 1'b0;
    end else begin
      if (cnt_en && cnt_inc[16] && !wr_lo && !wr_hi && !special_clr) begin
        overflow_flag <= 1'b1; // see [R22] [R4]
      end else if (fl_wr && writedata[`TGC_FL_OVF]) begin
        overflow_flag <= 1'b0;
      end
      if (gfall) begin
        gate_event_flag <= 1'b1; // see [R21]
      end else if (fl_wr && writedata[`TGC_FL_GATE]) begin
        gate_event_flag <= 1'b0;
      end
      if (match && !match_prev_ff) begin
        cmp_flag_ff <= 1'b1;
      end else if (fl_wr && writedata[`TGC_FL_CMP]) begin
        cmp_flag_ff <= 1'b0;
      end
      if (capture_event && ccp_ctrl_ff[`TGC_CC_CAP_EN]) begin
        cap_flag_ff <= 1'b1;
      end else if (fl_wr && writedata[`TGC_FL_CAP]) begin
        cap_flag_ff <= 1'b0;
      end
    end
  end

  // control register writes
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      timer_control_ff <= `TGC_RST_CTRL;
      gate_ctrl_ff     <= `TGC_RST_CTRL;
      ccp_ctrl_ff      <= 3'h0;
    end else if (wr_go) begin
      case (address)
        `TGC_REG_TIMER_CTRL: timer_control_ff <= writedata[7:0] & 8'hfd;
        `TGC_REG_GATE_CTRL:  gate_ctrl_ff     <= writedata[7:0] & 8'hf3;
        `TGC_REG_CCP_CTRL:   ccp_ctrl_ff      <= writedata[2:0];
        default: ;
      endcase
    end
  end

  // read multiplexer
  always @* begin
    case (address)
      `TGC_REG_TIMER_CTRL: nxt_rd = timer_control_ff;
      `TGC_REG_GATE_CTRL:  nxt_rd = gate_ctrl_ff | {4'h0, armed, gval, 2'h0}; // see [R16] [R17]
      `TGC_REG_COUNT_LOW:  nxt_rd = count_value[7:0];
      `TGC_REG_COUNT_HIGH: nxt_rd = count_value[15:8];
      `TGC_REG_CMP_LOW:    nxt_rd = compare_value_ff[7:0];
      `TGC_REG_CMP_HIGH:   nxt_rd = compare_value_ff[15:8];
      `TGC_REG_CCP_CTRL:   nxt_rd = {5'h00, ccp_ctrl_ff};
      default: nxt_rd = {4'h0, cap_flag_ff, cmp_flag_ff, gate_event_flag, overflow_flag};
    endcase
  end

  // bus answer and read data
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack_ff   <= 1'b0;
      readdata <= 32'h00000000;
    end else begin
      ack_ff <= (read | write) & ~ack_ff;
      if (read && !ack_ff) begin
        readdata <= {24'h000000, nxt_rd};
      end
    end
  end
endmodule

/* test/tgc_checker.sv */
`timescale 1ns/1ns
// timer bus and status checks
module tgc_checker (
  // clock and reset
  input wire        clk,
  input wire        resetn,
  // register bus
  input wire [2:0]  address,
  input wire        write,
  input wire [31:0] writedata,
  input wire [3:0]  byteenable,
  input wire        waitrequest,
  // status
  input wire        compare_event,
  input wire [15:0] count_value,
  input wire        overflow_flag,
  input wire        gate_event_flag,
  input wire        wdt_osc_enable
);
  wire      wr_ok = write && !waitrequest && byteenable[0]; // accepted write
  reg       ton_ff;   // mirror of timer on bit
  reg       wacc_ff;  // a write was accepted last edge
  reg [2:0] quiet_ff; // cycles stopped without writes
  // mirror timer on and count quiet cycles
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ton_ff   <= 1'b0;
      wacc_ff  <= 1'b0;
      quiet_ff <= 3'h0;
    end else begin
      wacc_ff <= write && !waitrequest;
      if (wr_ok && address == 3'h0) ton_ff <= writedata[0];
      if (ton_ff || (write && !waitrequest)) quiet_ff <= 3'h0;
      else if (quiet_ff != 3'h7) quiet_ff <= quiet_ff + 3'h1;
    end
  end
  wire      clr_ok = wr_ok && address == 3'h7; // flags write
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  ovf_sticky_a: assert property (
    overflow_flag && !(clr_ok && writedata[0]) |=> overflow_flag)
    else $error("overflow flag dropped");
  gate_sticky_a: assert property (
    gate_event_flag && !(clr_ok && writedata[1]) |=> gate_event_flag)
    else $error("gate flag dropped");
  roll_flag_a: assert property (
    count_value == 16'hffff ##1 count_value == 16'h0000 |-> ##[0:2] overflow_flag)
    else $error("rollover without overflow flag");
  count_step_a: assert property (
    !$stable(count_value) |-> count_value == $past(count_value) + 16'h0001
      || count_value == 16'h0000 || wacc_ff)
    else $error("count jumped");
  wdt_on_a: assert property (
    wr_ok && address == 3'h1 |=> wdt_osc_enable ==
      ($past(writedata[7]) && $past(writedata[1:0]) == 2'h3))
    else $error("watchdog osc enable wrong");
  cmp_pulse_a: assert property (compare_event |=> !compare_event)
    else $error("compare event too long");
  off_hold_a: assert property (quiet_ff == 3'h7 |=> $stable(count_value))
    else $error("count moved while off");
  wr_low_a: assert property (
    wr_ok && address == 3'h2 |=> count_value[7:0] == $past(writedata[7:0]))
    else $error("count low write lost");
  wr_high_a: assert property (
    wr_ok && address == 3'h3 |=> count_value[15:8] == $past(writedata[7:0]))
    else $error("count high write lost");
endmodule
bind tgc_timer tgc_checker i_tgc_checker (.clk(clk), .resetn(resetn), .address(address),
  .write(write), .writedata(writedata), .byteenable(byteenable), .waitrequest(waitrequest),
  .compare_event(compare_event), .count_value(count_value), .overflow_flag(overflow_flag),
  .gate_event_flag(gate_event_flag), .wdt_osc_enable(wdt_osc_enable));

/* test/tgc_partner.sv */
`timescale 1ns/1ns
// internal gate source timers
module tgc_partner (
  // clock and reset
  input  wire clk,
  input  wire resetn,
  // watchdog oscillator request
  input  wire wdt_osc_enable,
  // gate sources
  output reg  timer0_overflow,
  output reg  second_timer_match,
  output reg  wdt_scaler_overflow
);
  localparam [7:0] T2_PERIOD = 8'h1f; // second timer period, plain default
  reg [7:0] t0_ff;  // free running first timer
  reg [7:0] t2_ff;  // second timer count
  reg [5:0] wdt_ff; // watchdog scaler
  // first and second timers advance every clock, each pulse lasts one cycle
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      t0_ff               <= 8'h00;
      t2_ff               <= 8'h00;
      wdt_ff              <= 6'h00;
      timer0_overflow     <= 1'b0;
      second_timer_match  <= 1'b0;
      wdt_scaler_overflow <= 1'b0;
    end else begin
      timer0_overflow    <= (t0_ff == 8'hff); // pulse on wrap to zero
      t0_ff              <= t0_ff + 8'h01;
      second_timer_match <= (t2_ff == T2_PERIOD); // pulse as count restarts
      t2_ff              <= (t2_ff == T2_PERIOD) ? 8'h00 : t2_ff + 8'h01;
      // scaler runs only with its oscillator on
      wdt_ff              <= wdt_osc_enable ? wdt_ff + 6'h01 : 6'h00;
      wdt_scaler_overflow <= wdt_osc_enable && (wdt_ff == 6'h3f);
    end
  end
endmodule

/* test/tb_top.sv */
`timescale 1ns/1ns
`include "tgc_defines.vh"
module tb_top;
  reg         clk, resetn, read, write, capture_event;
  reg  [2:0]  address;    // register index
  reg  [31:0] writedata;  // bus write data
  reg  [3:0]  byteenable; // byte lanes
  reg  [3:0]  lines;      // gate pin, cap osc, crystal, clock pin
  wire [31:0] readdata;
  wire        waitrequest, compare_event, overflow_flag, gate_event_flag, wdt_osc_enable;
  wire        t0_ov, t2_m, wdt_ov;
  wire [15:0] count_value;
  integer     n_fail, checks, i, j, ncmp;
  reg  [7:0]  q;          // last read byte
  reg  [15:0] d, s, mx;   // count deltas
  tgc_timer i_tgc_timer (.clk(clk), .resetn(resetn), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .cap_sense_oscillator(lines[2]),
    .external_clock_pin(lines[0]), .crystal_in_pin(lines[1]), .gate_pin(lines[3]),
    .timer0_overflow(t0_ov), .second_timer_match(t2_m), .wdt_scaler_overflow(wdt_ov),
    .capture_event(capture_event), .compare_event(compare_event),
    .count_value(count_value), .overflow_flag(overflow_flag),
    .gate_event_flag(gate_event_flag), .wdt_osc_enable(wdt_osc_enable));
  tgc_partner i_tgc_partner (.clk(clk), .resetn(resetn), .wdt_osc_enable(wdt_osc_enable),
    .timer0_overflow(t0_ov), .second_timer_match(t2_m), .wdt_scaler_overflow(wdt_ov));
  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // compare and count, report at once
  task chk(input [63:0] what, input [15:0] seen, input [15:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("MISMATCH %0s exp %h seen %h", what, exp, seen);
    end
  endtask
  // one bus cycle, held until waitrequest low
  task bus(input w, input [2:0] a, input [7:0] v);
    @(posedge clk);
    address   <= a;
    writedata <= {24'h000000, v};
    read      <= !w;
    write     <= w;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    q = readdata[7:0];
    read  <= 1'b0;
    write <= 1'b0;
  endtask
  task wr(input [2:0] a, input [7:0] v);
    bus(1'b1, a, v);
  endtask
  task rd(input [2:0] a);
    bus(1'b0, a, 8'h00);
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // count advance over n cycles
  task delta(input integer n);
    @(posedge clk);
    s = count_value;
    repeat (n) @(posedge clk);
    d = count_value - s;
  endtask
  // n low then high periods on the masked lines
  task pulse(input [3:0] m, input integer n);
    repeat (n) begin
      lines <= lines & ~m;
      cyc(4);
      lines <= lines | m;
      cyc(4);
    end
  endtask
  // one gate pin pulse, count advance kept in d
  task spulse;
    @(posedge clk);
    s = count_value;
    lines[3] <= 1'b1;
    cyc(10);
    lines[3] <= 1'b0;
    cyc(6);
    d = count_value - s;
  endtask
  task close_out;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    #400000;
    n_fail = n_fail + 1;
    close_out;
  end
  // main sequence
  initial begin
    {resetn, read, write, capture_event, address, writedata, lines} = 0;
    byteenable = 4'h1;
    n_fail = 0;
    checks = 0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    for (i = 0; i < 8; i = i + 1) begin
      rd(i[2:0]);
      chk("rst", q & ((i == 1) ? 8'hfb : 8'hff), 16'h0);
    end
    $display("reset done");
    for (i = 0; i < 8; i = i + 1) begin
      wr(3'h0, {1'b0, i[2], i[1:0], 1'b0, i[0], 2'b01});
      cyc(8);
      delta(64);
      chk("rate", d, (i[2] ? 16'h40 : 16'h10) >> i[1:0]);
      wr(3'h0, 8'h00);
    end
    $display("rate done");
    for (j = 0; j < 3; j = j + 1) begin
      lines <= 4'h0;
      wr(3'h0, (j == 2) ? 8'hc1 : ((j == 1) ? 8'h89 : 8'h81));
      lines <= 4'h7;
      delta(8);
      chk("nofall", d, 16'h0);
      mx = count_value;
      for (i = 0; i < 3; i = i + 1) pulse(4'h1 << i, 3);
      chk("extcnt", count_value - mx, 16'h3);
      wr(3'h0, 8'h00);
    end
    $display("pins done");
    lines <= 4'h0;
    wr(3'h0, 8'h41);
    for (i = 0; i < 4; i = i + 1) begin
      wr(3'h1, {1'b1, i[1], 6'h00});
      lines[3] <= i[0];
      cyc(4);
      delta(16);
      chk("gate", d, (i[1] == i[0]) ? 16'h10 : 16'h0);
    end
    wr(3'h1, 8'h40);
    lines[3] <= 1'b0;
    cyc(4);
    delta(16);
    chk("nogate", d, 16'h10);
    rd(3'h1);
    chk("lvl0", q[2], 16'h0);
    lines[3] <= 1'b1;
    cyc(4);
    rd(3'h1);
    chk("lvl1", q[2], 16'h1);
    wr(3'h7, 8'h0f);
    lines[3] <= 1'b0;
    cyc(6);
    chk("gflag", gate_event_flag, 16'h1);
    wr(3'h1, 8'he0);
    cyc(4);
    delta(16);
    chk("tog0", d, 16'h0);
    for (i = 0; i < 3; i = i + 1) begin
      pulse(4'h8, 1);
      cyc(2);
      delta(16);
      chk("tog", d, i[0] ? 16'h0 : 16'h10);
    end
    wr(3'h0, 8'h40);
    wr(3'h0, 8'h41);
    cyc(2);
    delta(16);
    chk("togoff", d, 16'h0);
    lines[3] <= 1'b0;
    $display("gate done");
    wr(3'h1, 8'hd0);
    wr(3'h1, 8'hd8);
    rd(3'h1);
    chk("armed", q[3], 16'h1);
    spulse;
    chk("sp1", d > 16'h4 && d < 16'h10, 16'h1);
    rd(3'h1);
    chk("done", q[3], 16'h0);
    spulse;
    chk("sp2", d, 16'h0);
    wr(3'h1, 8'hd8);
    wr(3'h1, 8'hc8);
    rd(3'h1);
    chk("spmoff", q[3], 16'h0);
    wr(3'h0, 8'h00);
    $display("single done");
    for (i = 0; i < 4; i = i + 1) begin
      wr(3'h1, {6'h10, i[1:0]});
      cyc(4);
      wr(3'h7, 8'h0f);
      cyc(300);
      chk("src", gate_event_flag, i == 1 || i == 2);
      chk("wdtoff", wdt_osc_enable, 16'h0);
    end
    wr(3'h1, 8'hc3);
    cyc(1);
    chk("wdton", wdt_osc_enable, 16'h1);
    wr(3'h7, 8'h0f);
    cyc(300);
    chk("wdtsrc", gate_event_flag, 16'h1);
    wr(3'h1, 8'h00);
    $display("sources done");
    wr(3'h2, 8'hfd);
    wr(3'h3, 8'hff);
    wr(3'h7, 8'h0f);
    cyc(1);
    chk("ovf0", overflow_flag, 16'h0);
    wr(3'h0, 8'h41);
    cyc(10);
    chk("ovf1", overflow_flag, 16'h1);
    chk("wrap", count_value < 16'h10, 16'h1);
    wr(3'h0, 8'h00);
    wr(3'h2, 8'h34);
    wr(3'h3, 8'h12);
    wr(3'h6, 8'h01);
    capture_event <= 1'b1;
    @(posedge clk);
    capture_event <= 1'b0;
    cyc(3);
    rd(3'h4);
    chk("caplo", q, 16'h34);
    rd(3'h5);
    chk("caphi", q, 16'h12);
    $display("capture done");
    wr(3'h6, 8'h00);
    wr(3'h4, 8'h10);
    wr(3'h5, 8'h00);
    wr(3'h2, 8'h00);
    wr(3'h3, 8'h00);
    wr(3'h7, 8'h0f);
    wr(3'h6, 8'h06);
    wr(3'h0, 8'h41);
    mx = 16'h0;
    ncmp = 0;
    repeat (200) begin
      @(posedge clk);
      if (count_value > mx) mx = count_value;
      if (compare_event === 1'b1) ncmp = ncmp + 1;
    end
    chk("period", mx, 16'h10);
    chk("ncmp", ncmp > 5, 16'h1);
    chk("noovf", overflow_flag, 16'h0);
    rd(3'h7);
    chk("cmpfl", q[2], 16'h1);
    wr(3'h0, 8'h00);
    wr(3'h6, 8'h00);
    byteenable <= 4'h0;
    wr(3'h4, 8'haa);
    byteenable <= 4'h1;
    rd(3'h4);
    chk("lane", q, 16'h10);
    $display("compare done");
    close_out;
  end
endmodule
